// [include/sew_consts.vh]
/*
 * constants of the secure write command block: register offsets, zone
 * codes, command fields, policy fields and status codes.
 * assumes a 32-bit apb master and an eeprom port that answers with ack.
 */
`ifndef SEW_CONSTS_VH
`define SEW_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define SEW_OFF_CTRL        12'h000
`define SEW_OFF_CMD         12'h004
`define SEW_OFF_STATUS      12'h008
`define SEW_OFF_DATA        12'h020
`define SEW_OFF_MAC         12'h040
`define SEW_OFF_END         12'h060
// ****************************************
// command fields
// ****************************************
`define SEW_OPC_WRITE       8'h12
`define SEW_ZB_SIZE32       7
`define SEW_ZB_ENC          6
`define SEW_ZONE_CFG        2'h0
`define SEW_ZONE_OTP        2'h1
`define SEW_ZONE_DATA       2'h2
`define SEW_CFG_BLOCKS      5'h03
`define SEW_OTP_BLOCKS      5'h02
`define SEW_DATA_BLOCKS     5'h10
// ****************************************
// slot policy word fields and the otp consume mode value
// ****************************************
`define SEW_POL_ENC         14
`define SEW_POL_WCFG_HI     15
`define SEW_POL_WCFG_LO     12
`define SEW_POL_WKEY_HI     11
`define SEW_POL_WKEY_LO     8
`define SEW_POL_SECRET      7
`define SEW_WCFG_ALWAYS     4'h0
`define SEW_OTP_CONSUME     8'h55
// ****************************************
// status codes and reset values
// ****************************************
`define SEW_ST_OK           8'h00
`define SEW_ST_MAC          8'h01
`define SEW_ST_PARSE        8'h03
`define SEW_ST_EXEC         8'h0F
`define SEW_ST_RESET        8'hFF
`endif

// [core/sew_write_cmd.v]
/*
 * write command engine: apb register file holding one write command,
 * its value and mac fields; checks zone, size, address, lock state and
 * slot policy, decrypts with the scratch key, has the mac of encrypted data
 * zone writes checked by an outside sha engine and only then programs the eeprom.
 * assumes lock state, policy words and scratch key come from same-clock
 * logic, and that the sha engine and eeprom answer with one-cycle pulses.
 */
`include "sew_consts.vh"

module sew_write_cmd (
    input  wire         sys_clk,          // 200 mhz clock
    input  wire         arst_n,           // async reset, active low
    input  wire         psel,             // apb select
    input  wire         penable,          // apb access phase
    input  wire         pwrite,           // apb direction
    input  wire [11:0]  paddr,            // apb byte address
    input  wire [31:0]  pwdata,           // apb write data
    output reg          pready,           // apb ready
    output reg  [31:0]  prdata,           // apb read data
    output reg          pslverr,          // apb error, unmapped or unaligned address
    input  wire         config_locked,    // configuration zone locked
    input  wire         data_locked,      // data and otp zones locked
    input  wire [7:0]   otp_policy_byte,  // otp zone mode
    input  wire [255:0] slot_policy_words,// 16 slot policy words, slot 0 low
    input  wire [15:0]  odd_slot_source_setting, // origin wanted per odd slot
    input  wire [95:0]  cfg_ro_mask,      // config bytes never writable
    input  wire [255:0] scratch_key_value,// scratch key register
    input  wire         scratch_key_valid,// scratch key valid
    input  wire         scratch_key_digest_generate_command,// made by digest generation
    input  wire [3:0]   key_slot_tag,     // slot used to make scratch key
    input  wire         key_origin_flag,  // 1 when origin is random
    output reg          sha_start,        // pulse: hash the write message
    output reg  [31:0]  sha_params,       // address, zone and opcode
    output reg  [255:0] sha_text,         // plaintext value
    input  wire         sha_done,         // pulse: digest ready
    input  wire [255:0] sha_digest,       // computed mac
    output reg          ee_rd,            // read request, held to ack
    output reg          ee_wr,            // write request, held to ack
    output reg  [1:0]   ee_zone,          // zone of access
    output reg  [3:0]   ee_block,         // block or slot
    output reg  [255:0] ee_wdata,         // block write data
    output reg  [31:0]  ee_be,            // byte enables
    input  wire         ee_ack,           // pulse: access done
    input  wire [255:0] ee_rdata,         // block read data
    output reg          busy,             // command in progress
    output reg  [7:0]   status_byte       // last answer
);
    localparam S_IDLE  = 3'd0;
    localparam S_CHECK = 3'd1;
    localparam S_MAC   = 3'd2;
    localparam S_READ  = 3'd3;
    localparam S_WRITE = 3'd4;

    reg  [2:0]   state_reg;
    reg  [31:0]  cmd_reg;
    reg  [31:0]  data_reg [0:7];
    reg  [31:0]  mac_reg  [0:7];
    wire [255:0] data_flat;
    wire [255:0] mac_flat;
    wire         apb_done;
    wire         map_ok;

    // ****************************************
    // apb slave: one wait state, then registered answer
    // ****************************************
    assign apb_done = psel & penable & pready;
    assign map_ok   = (paddr < `SEW_OFF_END) && (paddr[1:0] == 2'h0);

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~map_ok;
            prdata  <= 32'h0000_0000;
            if (psel & penable & ~pready & ~pwrite)
            begin
                if (paddr == `SEW_OFF_CTRL)
                    prdata <= {31'h0, busy};
                else if (paddr == `SEW_OFF_CMD)
                    prdata <= cmd_reg;
                else if (paddr == `SEW_OFF_STATUS)
                    prdata <= {23'h0, busy, status_byte};
                else if (paddr >= `SEW_OFF_DATA && paddr < `SEW_OFF_MAC)
                    prdata <= data_reg[paddr[4:2]];
                else if (paddr >= `SEW_OFF_MAC && paddr < `SEW_OFF_END)
                    prdata <= mac_reg[paddr[4:2]];
            end
        end
    end

    // value and mac words; ignored while a command runs
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_word
            assign data_flat[gi*32 +: 32] = data_reg[gi];
            assign mac_flat[gi*32 +: 32]  = mac_reg[gi];
            always @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    data_reg[gi] <= 32'h0000_0000;
                    mac_reg[gi]  <= 32'h0000_0000;
                end
                else if (apb_done && pwrite && !busy)
                begin
                    if (paddr == `SEW_OFF_DATA + gi * 4)
                        data_reg[gi] <= pwdata;
                    if (paddr == `SEW_OFF_MAC + gi * 4)
                        mac_reg[gi] <= pwdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // command decode
    // ****************************************
    wire [7:0]  opcode   = cmd_reg[7:0];
    wire [7:0]  zone_sel = cmd_reg[15:8];
    wire [15:0] address  = cmd_reg[31:16];
    wire        size32   = zone_sel[`SEW_ZB_SIZE32];
    wire [1:0]  zone     = zone_sel[1:0];
    wire [3:0]  blk      = address[6:3];
    wire [2:0]  word     = address[2:0];
    wire [15:0] pol      = slot_policy_words[blk*16 +: 16];
    wire [3:0]  wcfg     = pol[`SEW_POL_WCFG_HI:`SEW_POL_WCFG_LO];
    wire        always_w = (wcfg == `SEW_WCFG_ALWAYS);
    wire        is_data  = (zone == `SEW_ZONE_DATA);
    wire        is_otp   = (zone == `SEW_ZONE_OTP);
    wire        is_cfg   = (zone == `SEW_ZONE_CFG);
    // after lock the zone bit is ignored for slots
    wire        enc      = (data_locked && is_data) ? pol[`SEW_POL_ENC]
                                                    : zone_sel[`SEW_ZB_ENC];
    wire [4:0]  zblocks  = is_cfg ? `SEW_CFG_BLOCKS :
                           is_otp ? `SEW_OTP_BLOCKS : `SEW_DATA_BLOCKS;
    wire [31:0] be       = size32 ? 32'hFFFF_FFFF
                                  : (32'h0000_000F << {word, 2'b00});
    wire [127:0] ro_pad  = {32'h0000_0000, cfg_ro_mask};
    wire        ro_hit   = |(ro_pad[blk[1:0]*32 +: 32] & be);
    wire [255:0] plain   = enc ? (data_flat ^ scratch_key_value)
                               : data_flat;
    wire [255:0] wdata   = size32 ? plain : {8{plain[31:0]}};

    reg  [7:0]  chk_code;
    reg         need_mac;
    reg         consume;

    always @*
    begin
        chk_code = `SEW_ST_OK;
        need_mac = 1'b0;
        consume  = 1'b0;
        if (opcode != `SEW_OPC_WRITE || zone_sel[5:2] != 4'h0 || zone == 2'h3)
            chk_code = `SEW_ST_PARSE;
        else if ({1'b0, blk} >= zblocks)
            chk_code = `SEW_ST_PARSE;
        else if (is_cfg)
        begin
            if (config_locked || zone_sel[`SEW_ZB_ENC])
                chk_code = `SEW_ST_EXEC;
            else if (ro_hit)
                chk_code = `SEW_ST_EXEC;
        end
        else if (!config_locked)
            chk_code = `SEW_ST_EXEC;
        else if (!data_locked && !size32)
            chk_code = `SEW_ST_EXEC;
        else if (!size32 && (enc || (is_data && (pol[`SEW_POL_SECRET] || !always_w))))
            chk_code = `SEW_ST_EXEC;
        else if (is_otp && data_locked && enc)
            chk_code = `SEW_ST_EXEC;
        else if (is_otp && data_locked && otp_policy_byte != `SEW_OTP_CONSUME)
            chk_code = `SEW_ST_EXEC;
        else if (is_data && data_locked && !always_w && !pol[`SEW_POL_ENC])
            chk_code = `SEW_ST_EXEC;
        else if (enc && !(scratch_key_valid && scratch_key_digest_generate_command))
            chk_code = `SEW_ST_EXEC;
        else if (enc && data_locked &&
                 key_slot_tag != pol[`SEW_POL_WKEY_HI:`SEW_POL_WKEY_LO])
            chk_code = `SEW_ST_EXEC;
        else if (enc && is_data && !blk[0] && !key_origin_flag)
            chk_code = `SEW_ST_EXEC;
        else if (enc && is_data && blk[0] &&
                 key_origin_flag != odd_slot_source_setting[blk])
            chk_code = `SEW_ST_EXEC;
        else
        begin
            need_mac = enc && is_data;
            consume  = is_otp && data_locked;
        end
        // otp unlocked: every otp byte writable
    end

    // ****************************************
    // command sequencer
    // ****************************************
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg   <= S_IDLE;
            cmd_reg     <= 32'h0000_0000;
            busy        <= 1'b0;
            status_byte <= `SEW_ST_RESET;
            sha_start   <= 1'b0;
            sha_params  <= 32'h0000_0000;
            sha_text    <= 256'h0;
            ee_rd       <= 1'b0;
            ee_wr       <= 1'b0;
            ee_zone     <= 2'h0;
            ee_block    <= 4'h0;
            ee_wdata    <= 256'h0;
            ee_be       <= 32'h0000_0000;
        end
        else
        begin
            sha_start <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (apb_done && pwrite && paddr == `SEW_OFF_CMD)
                        cmd_reg <= pwdata;
                    if (apb_done && pwrite && paddr == `SEW_OFF_CTRL && pwdata[0])
                    begin
                        busy      <= 1'b1;
                        state_reg <= S_CHECK;
                    end
                end
                S_CHECK:
                begin
                    // nothing touches the eeprom until every check passed
                    ee_zone  <= zone;
                    ee_block <= blk;
                    ee_wdata <= wdata;
                    ee_be    <= be;
                    if (chk_code != `SEW_ST_OK)
                    begin
                        status_byte <= chk_code;
                        busy        <= 1'b0;
                        state_reg   <= S_IDLE;
                    end
                    else if (need_mac)
                    begin
                        sha_start  <= 1'b1;
                        sha_params <= cmd_reg;
                        sha_text   <= plain;
                        state_reg  <= S_MAC;
                    end
                    else if (consume)
                    begin
                        ee_rd     <= 1'b1;
                        state_reg <= S_READ;
                    end
                    else
                    begin
                        ee_wr     <= 1'b1;
                        state_reg <= S_WRITE;
                    end
                end
                S_MAC:
                begin
                    if (sha_done)
                    begin
                        if (sha_digest == mac_flat)
                        begin
                            ee_wr     <= 1'b1;
                            state_reg <= S_WRITE;
                        end
                        else
                        begin
                            status_byte <= `SEW_ST_MAC;
                            busy        <= 1'b0;
                            state_reg   <= S_IDLE;
                        end
                    end
                end
                S_READ:
                begin
                    if (ee_ack)
                    begin
                        ee_rd     <= 1'b0;
                        ee_wdata  <= ee_rdata & ee_wdata;
                        ee_wr     <= 1'b1;
                        state_reg <= S_WRITE;
                    end
                end
                S_WRITE:
                begin
                    if (ee_ack)
                    begin
                        ee_wr       <= 1'b0;
                        status_byte <= `SEW_ST_OK;
                        busy        <= 1'b0;
                        state_reg   <= S_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= S_IDLE;
                    busy      <= 1'b0;
                end
            endcase
        end
    end

endmodule // sew_write_cmd

// [verification/sew_write_cmd_properties.sv]
/* checker for the write command block: apb timing, eeprom gating, byte enables.
   assumes it is bound to sew_write_cmd and sees only its ports. */
module sew_wc_props (
    input wire         sys_clk,       // clock
    input wire         arst_n,        // reset, active low
    input wire         psel,          // apb select
    input wire         penable,       // apb access
    input wire         pwrite,        // apb direction
    input wire [11:0]  paddr,         // apb address
    input wire [31:0]  pwdata,        // apb write data
    input wire         pready,        // apb ready
    input wire         pslverr,       // apb error
    input wire         config_locked, // config zone lock
    input wire         sha_start,     // hash start
    input wire         ee_rd,         // eeprom read
    input wire         ee_wr,         // eeprom write
    input wire [1:0]   ee_zone,       // eeprom zone
    input wire [3:0]   ee_block,      // eeprom block
    input wire [255:0] ee_wdata,      // eeprom data
    input wire [31:0]  ee_be,         // byte enables
    input wire         ee_ack,        // eeprom answer
    input wire         busy,          // command running
    input wire [7:0]   status_byte    // result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cmd_q;
    // last command word written, to know size and target
    always @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            cmd_q <= 32'h0;
        else if (psel && penable && pready && pwrite && paddr == 12'h004)
            cmd_q <= pwdata;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_slverr_map: assert property (pready |-> pslverr == (paddr >= 12'h060 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong");
    a_start_busy: assert property (psel && penable && pready && pwrite && paddr == 12'h000
        && pwdata[0] && !busy |=> busy) else $error("start ignored");
    a_idle_quiet: assert property (!busy |-> !ee_wr && !ee_rd) else $error("eeprom access idle");
    a_wr_held: assert property (ee_wr && !ee_ack |=> ee_wr && $stable(ee_wdata) && $stable(ee_be))
        else $error("write request not held");
    a_done_ok: assert property (ee_wr && ee_ack |=> !busy && status_byte == 8'h00)
        else $error("no success status");
    a_be_size: assert property (ee_wr |-> ee_be == (cmd_q[15] ? 32'hFFFFFFFF
        : 32'hF << {cmd_q[18:16], 2'h0})) else $error("byte enables wrong");
    a_target: assert property (ee_wr |-> ee_block == cmd_q[22:19] && ee_zone == cmd_q[9:8])
        else $error("write target wrong");
    a_cfg_gate: assert property (ee_wr && ee_zone != 2'h0 |-> config_locked)
        else $error("write before config lock");
    a_sha_pulse: assert property (sha_start |=> !sha_start) else $error("sha start held");
endmodule // sew_wc_props

bind sew_write_cmd sew_wc_props u_props (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .config_locked, .sha_start, .ee_rd, .ee_wr, .ee_zone,
    .ee_block, .ee_wdata, .ee_be, .ee_ack, .busy, .status_byte);

// [verification/sew_ee_model.sv]
/* eeprom and sha engine model at the far side of the write command block.
   assumes the block's clock; slow stretches every answer. */
module sew_ee_model (
    input  wire         sys_clk,    // clock
    input  wire         arst_n,     // reset, active low
    input  wire         ee_rd,      // read request
    input  wire         ee_wr,      // write request
    input  wire [255:0] ee_wdata,   // write data
    input  wire [31:0]  ee_be,      // byte enables
    input  wire         sha_start,  // hash start
    input  wire         slow,       // late answers
    input  wire [255:0] rd_val,     // stored block
    input  wire [255:0] dig,        // digest to give
    output logic        ee_ack,     // access done
    output logic [255:0] ee_rdata,  // read data
    output logic        sha_done,   // digest ready
    output logic [255:0] sha_digest // digest
);
    timeunit 1ns;
    timeprecision 1ps;
    int          wr_count;
    logic [255:0] last_wdata;
    logic [31:0] last_be;
    logic [3:0]  cnt;
    logic [3:0]  sc;
    always @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
        begin
            {ee_ack, sha_done, cnt, sc, wr_count} <= '0;
            ee_rdata <= '0;
            sha_digest <= '0;
        end
        else
        begin
            ee_ack <= 1'b0;
            sha_done <= (sc == 4'h1); // [17]
            sc <= sha_start ? (slow ? 4'h6 : 4'h2) : (sc != 4'h0 ? sc - 4'h1 : sc);
            sha_digest <= (sc == 4'h1) ? dig : ~dig;
            ee_rdata <= ~ee_rdata; // released lines keep changing
            if ((ee_rd || ee_wr) && !ee_ack)
                if (cnt == (slow ? 4'h4 : 4'h0))
                begin
                    ee_ack <= 1'b1;
                    cnt <= 4'h0;
                    if (ee_rd)
                        ee_rdata <= rd_val;
                    if (ee_wr)
                    begin
                        wr_count <= wr_count + 1;
                        last_wdata <= ee_wdata;
                        last_be <= ee_be;
                    end
                end
                else
                    cnt <= cnt + 4'h1;
        end
endmodule // sew_ee_model

// [verification/tb.sv]
/* self-checking bench of the write command block: apb host, random data, corner cases.
   assumes the bound checker and the eeprom model beside the block. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, se;
    logic config_locked = 0, data_locked = 0, scratch_key_valid = 0, scratch_key_digest_generate_command = 0;
    logic key_origin_flag = 0, pready, pslverr, sha_start, sha_done, ee_rd, ee_wr, ee_ack, busy;
    logic [11:0]  paddr = 0;
    logic [31:0]  pwdata = 0, prdata, ee_be, r, seed = 32'd38885, sha_params;
    logic [7:0]   otp_policy_byte = 0, status_byte;
    logic [255:0] slot_policy_words = 0, scratch_key_value = 0, rd_val = 0, dig = 0, val, mac_v;
    logic [255:0] ee_wdata, ee_rdata, sha_digest, sha_text;
    logic [15:0]  odd_slot_source_setting = 0;
    logic [95:0]  cfg_ro_mask = 0;
    logic [3:0]   key_slot_tag = 0, ee_block;
    logic [1:0]   ee_zone;
    int errors = 0, check_count = 0, tn = 0;
    sew_write_cmd dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .config_locked, .data_locked, .otp_policy_byte, .slot_policy_words,
        .odd_slot_source_setting, .cfg_ro_mask, .scratch_key_value, .scratch_key_valid,
        .scratch_key_digest_generate_command, .key_slot_tag, .key_origin_flag, .sha_start, .sha_params,
        .sha_text, .sha_done, .sha_digest, .ee_rd, .ee_wr, .ee_zone, .ee_block, .ee_wdata,
        .ee_be, .ee_ack, .ee_rdata, .busy, .status_byte);
    sew_ee_model m_ee (.sys_clk, .arst_n, .ee_rd, .ee_wr, .ee_wdata, .ee_be, .sha_start, .slow,
        .rd_val, .dig, .ee_ack, .ee_rdata, .sha_done, .sha_digest);
    initial forever #2.5 sys_clk = ~sys_clk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [255:0] ex(int m);
        case (m)
            0: ex = val;
            1: ex = val ^ scratch_key_value;
            2: ex = rd_val & val;
            default: ex = {8{val[31:0]}};
        endcase
    endfunction
    task chk(input string nm, input logic [287:0] s, input logic [287:0] e);
        check_count++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready", pready, 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // fresh random data, the given lock state and a default key state
    task st(input logic c, input logic d, input logic [7:0] o);
        config_locked <= c;
        data_locked <= d;
        otp_policy_byte <= o;
        {slot_policy_words, cfg_ro_mask, odd_slot_source_setting, key_slot_tag} <= '0;
        {scratch_key_valid, scratch_key_digest_generate_command, key_origin_flag} <= 3'h7;
        slow <= rnd() & 1;
        for (int k = 0; k < 8; k++)
        begin
            val[32*k+:32] = rnd();
            mac_v[32*k+:32] = rnd();
            scratch_key_value[32*k+:32] <= rnd();
            rd_val[32*k+:32] <= rnd();
        end
        dig <= mac_v;
    endtask
    // one whole command: fields, value and mac words, start, poll
    task run(input logic [7:0] op, zb, input logic [15:0] ad, input logic [7:0] es, input int m);
        int n0, n;
        n0 = m_ee.wr_count;
        apb(1'b1, 12'h004, {ad, zb, op});
        apb(1'b0, 12'h004, 32'h0);
        chk("cmd", r, {ad, zb, op});
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 12'(32 + 4 * k), val[32*k+:32]);
            apb(1'b1, 12'(64 + 4 * k), mac_v[32*k+:32]);
        end
        apb(1'b1, 12'h000, 32'h1);
        n = 0;
        r = 32'h100;
        while (r[8] !== 1'b0 && n < 100)
        begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end
        tn++;
        chk("busy", r[8], 1'b0);
        if (es == 8'hEE)
            chk("fails", r[7:0] == 8'h00, 1'b0);
        else
            chk("status", r[7:0], es);
        chk("writes", m_ee.wr_count - n0, es == 8'h00);
        if (es == 8'h00)
        begin
            chk("wdata", m_ee.last_wdata, ex(m));
            chk("be", m_ee.last_be, m == 3 ? 32'hF << (4 * ad[2:0]) : 32'hFFFFFFFF);
        end
        if (es == 8'h00 && m == 1)
        begin
            chk("sha_params", sha_params, {ad, zb, op});
            chk("sha_text", sha_text, ex(1));
        end
        $display("test %0d done", tn);
    endtask
    initial
    begin
        #100us;
        errors++;
        $display("watchdog expired");
        tally_and_finish;
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk("status_reset", r, 32'h000000FF);
        apb(1'b0, 12'h060, 32'h0);
        chk("unmapped", {r, se}, {32'h0, 1'b1});
        apb(1'b1, 12'h062, 32'h1);
        chk("unaligned", se, 1'b1);
        st(0, 0, 8'h00); run(8'h12, 8'h80, 16'h0008, 8'h00, 0);
        st(0, 0, 8'h00); run(8'h12, 8'h81, 16'h0000, 8'h0F, 0);
        st(0, 0, 8'h00); run(8'h12, 8'h82, 16'h0000, 8'h0F, 0);
        st(0, 0, 8'h00); run(8'h13, 8'h80, 16'h0000, 8'h03, 0);
        st(0, 0, 8'h00); run(8'h12, 8'h84, 16'h0000, 8'h03, 0);
        st(1, 1, 8'h00); run(8'h12, 8'h83, 16'h0000, 8'h03, 0);
        st(0, 0, 8'h00); run(8'h12, 8'h80, 16'h0018, 8'h03, 0);
        st(1, 0, 8'h00); run(8'h12, 8'h80, 16'h0000, 8'h0F, 0);
        st(0, 0, 8'h00); run(8'h12, 8'hC0, 16'h0000, 8'hEE, 0);
        st(0, 0, 8'h00); cfg_ro_mask[40] <= 1'b1; run(8'h12, 8'h80, 16'h0008, 8'hEE, 0);
        st(1, 0, 8'h00); run(8'h12, 8'h82, 16'h0078, 8'h00, 0);
        st(1, 0, 8'h00); run(8'h12, 8'h02, 16'h0000, 8'hEE, 0);
        st(1, 0, 8'h00); run(8'h12, 8'h81, 16'h0008, 8'h00, 0);
        st(1, 1, 8'hAA); run(8'h12, 8'h81, 16'h0000, 8'h0F, 0);
        st(1, 1, 8'h00); run(8'h12, 8'h81, 16'h0000, 8'h0F, 0);
        st(1, 1, 8'h55); run(8'h12, 8'h81, 16'h0008, 8'h00, 2);
        st(1, 1, 8'h55); run(8'h12, 8'hC1, 16'h0000, 8'hEE, 0);
        st(1, 1, 8'h00); run(8'h12, 8'h02, 16'h0015, 8'h00, 3);
        st(1, 1, 8'h00); slot_policy_words[39] <= 1'b1;
        run(8'h12, 8'h02, 16'h0015, 8'h0F, 0);
        st(1, 0, 8'h00); key_slot_tag <= 4'h7;
        run(8'h12, 8'hC2, 16'h0010, 8'h00, 1);
        st(1, 0, 8'h00); dig <= ~mac_v; run(8'h12, 8'hC2, 16'h0010, 8'h01, 0);
        st(1, 0, 8'h00); scratch_key_digest_generate_command <= 1'b0;
        run(8'h12, 8'hC2, 16'h0010, 8'h0F, 0);
        st(1, 0, 8'h00); scratch_key_valid <= 1'b0;
        run(8'h12, 8'hC2, 16'h0010, 8'h0F, 0);
        st(1, 0, 8'h00); key_origin_flag <= 1'b0;
        run(8'h12, 8'hC2, 16'h0010, 8'h0F, 0);
        st(1, 0, 8'h00); run(8'h12, 8'hC2, 16'h0018, 8'h0F, 0);
        st(1, 0, 8'h00); odd_slot_source_setting[3] <= 1'b1;
        run(8'h12, 8'hC2, 16'h0018, 8'h00, 1);
        st(1, 1, 8'h00); slot_policy_words[47:32] <= 16'h4300; key_slot_tag <= 4'h2;
        run(8'h12, 8'h82, 16'h0010, 8'h0F, 0);
        st(1, 1, 8'h00); slot_policy_words[47:32] <= 16'h4300; key_slot_tag <= 4'h3;
        run(8'h12, 8'h82, 16'h0010, 8'h00, 1);
        tally_and_finish;
    end
endmodule // tb
